// ### rtl/drive_protection_monitor.v
// Protection monitor: power-unit thermal/overload, blocked motor, stall
// and motor temperature evaluation with register access.
// Assumes measured values come from logic on i_ref_clk; pin level
// inputs (sensor presence) are synchronised here.
`timescale 1ns/100ps
`include "drive_protection_monitor_consts.vh"
module drive_protection_monitor (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  input  wire [15:0] i_converter_load_pct,
  input  wire [15:0] i_heatsink_temp,
  input  wire [15:0] i_junction_temp,
  input  wire [15:0] i_inlet_air_temp,
  input  wire [15:0] i_speed_abs,
  input  wire        i_vector_control,
  input  wire        i_encoder_closed_loop,
  input  wire        i_speed_ctrl_at_limit,
  input  wire        i_current_limit_reached,
  input  wire [15:0] i_speed_deviation,
  input  wire [15:0] i_model_error,
  input  wire [15:0] i_sensor_temp,
  input  wire [15:0] i_ptc_ohm,
  input  wire        i_sensor_present,
  output reg         o_i2t_alarm,
  output reg         o_i2t_trip,
  output reg         o_heatsink_alarm,
  output reg         o_heatsink_trip,
  output reg         o_junction_temp_alarm,
  output reg         o_junction_temp_trip,
  output reg         o_inlet_air_alarm,
  output reg         o_pulse_freq_reduce,
  output reg         o_output_freq_reduce,
  output reg         o_power_off,
  output reg         o_motor_blocked,
  output reg         o_motor_blocked_trip,
  output reg  [15:0] o_control_status_word_three,
  output reg         o_motor_stalled_trip,
  output reg  [15:0] o_motor_temp,
  output reg         o_motor_overtemp_alarm,
  output reg         o_motor_overtemp_trip,
  output reg         o_current_ceiling_reduce,
  output reg         o_sensor_fault_alarm,
  output reg         o_sensor_fault_trip,
  output reg         o_sensor_missing_alarm,
  output reg         o_use_model_temp
);

  // ==========================================================================
  // Helpers
  function gte;
    input [15:0] a;
    input [15:0] b;
    begin
      gte = ($signed(a) >= $signed(b));
    end
  endfunction

  function [15:0] sat;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if ($signed(v) < $signed(lo)) begin
        sat = lo;
      end else if ($signed(v) > $signed(hi)) begin
        sat = hi;
      end else begin
        sat = v;
      end
    end
  endfunction

  // ==========================================================================
  // Registers
  reg [15:0] ctrl_reg;
  reg [15:0] i2t_alarm_reg;
  reg [15:0] hs_margin_reg;
  reg [15:0] jt_margin_reg;
  reg [15:0] block_speed_reg;
  reg [15:0] block_delay_reg;
  reg [15:0] stall_speed_reg;
  reg [15:0] stall_fault_reg;
  reg [15:0] chg_speed_reg;
  reg [15:0] chg_hyst_reg;
  reg [15:0] stall_delay_reg;
  reg [15:0] mot_alarm_reg;
  reg [15:0] mot_trip_reg;
  reg [15:0] mot_timer_reg;
  reg [15:0] sens_timer_reg;
  reg [15:0] rdata_next;
  reg [15:0] status_word;

  wire [1:0] resp_sel   = ctrl_reg[`CTRL_RESP_LSB +: 2];
  wire [3:0] temp_src   = ctrl_reg[`CTRL_SRC_LSB +: 4];
  wire [1:0] sens_kind  = ctrl_reg[`CTRL_KIND_LSB +: 2];
  wire [1:0] mot_resp   = ctrl_reg[`CTRL_MRESP_LSB +: 2];
  wire       induction  = ctrl_reg[`CTRL_INDUCTION_BIT];

  // Alarm levels except the inlet air alarm, margins, delays and the motor trip level are writable; power-unit shutdown levels are constants.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg        <= `CTRL_RESET;
      i2t_alarm_reg   <= `I2T_ALARM_RESET;
      hs_margin_reg   <= `HS_MARGIN_RESET;
      jt_margin_reg   <= `JT_MARGIN_RESET;
      block_speed_reg <= 16'h0000;
      block_delay_reg <= 16'h0000;
      stall_speed_reg <= 16'h0000;
      stall_fault_reg <= 16'h0000;
      chg_speed_reg   <= 16'h0000;
      chg_hyst_reg    <= `CHG_HYST_RESET;
      stall_delay_reg <= 16'h0000;
      mot_alarm_reg   <= `MOT_ALARM_RESET;
      mot_trip_reg    <= `MOT_TRIP_RESET;
      mot_timer_reg   <= 16'h0000;
      sens_timer_reg  <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        `REG_CTRL:          ctrl_reg        <= i_wdata;
        `REG_I2T_ALARM:     i2t_alarm_reg   <= i_wdata;
        `REG_HS_MARGIN:     hs_margin_reg   <= i_wdata;
        `REG_JT_MARGIN:     jt_margin_reg   <= i_wdata;
        `REG_BLOCK_SPEED:   block_speed_reg <= i_wdata;
        `REG_BLOCK_DELAY:   block_delay_reg <= i_wdata;
        `REG_STALL_SPEED:   stall_speed_reg <= i_wdata;
        `REG_STALL_FAULT:   stall_fault_reg <= i_wdata;
        `REG_CHG_SPEED:     chg_speed_reg   <= i_wdata;
        `REG_CHG_HYST:      chg_hyst_reg    <= i_wdata;
        `REG_STALL_DELAY:   stall_delay_reg <= i_wdata;
        `REG_MOT_ALARM_LVL: mot_alarm_reg   <= i_wdata;
        `REG_MOT_TRIP_LVL:  mot_trip_reg    <= i_wdata;
        `REG_MOT_TIMER:     mot_timer_reg   <= i_wdata;
        `REG_SENS_TIMER:    sens_timer_reg  <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    status_word = {4'h0, o_sensor_missing_alarm, o_sensor_fault_trip,
                   o_sensor_fault_alarm, o_motor_overtemp_trip,
                   o_motor_overtemp_alarm, o_motor_stalled_trip,
                   o_motor_blocked_trip, o_junction_temp_trip,
                   o_heatsink_trip, o_i2t_trip, o_junction_temp_alarm,
                   o_i2t_alarm | o_heatsink_alarm};
    case (i_addr)
      `REG_CTRL:          rdata_next = ctrl_reg;
      `REG_I2T_ALARM:     rdata_next = i2t_alarm_reg;
      `REG_HS_MARGIN:     rdata_next = hs_margin_reg;
      `REG_JT_MARGIN:     rdata_next = jt_margin_reg;
      `REG_BLOCK_SPEED:   rdata_next = block_speed_reg;
      `REG_BLOCK_DELAY:   rdata_next = block_delay_reg;
      `REG_STALL_SPEED:   rdata_next = stall_speed_reg;
      `REG_STALL_FAULT:   rdata_next = stall_fault_reg;
      `REG_CHG_SPEED:     rdata_next = chg_speed_reg;
      `REG_CHG_HYST:      rdata_next = chg_hyst_reg;
      `REG_STALL_DELAY:   rdata_next = stall_delay_reg;
      `REG_MOT_ALARM_LVL: rdata_next = mot_alarm_reg;
      `REG_MOT_TRIP_LVL:  rdata_next = mot_trip_reg;
      `REG_MOT_TIMER:     rdata_next = mot_timer_reg;
      `REG_SENS_TIMER:    rdata_next = sens_timer_reg;
      default:            rdata_next = status_word;
    endcase
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ==========================================================================
  // Millisecond tick and pin synchroniser
  reg [15:0] tick_cnt_reg;
  reg        tick_reg;
  reg        present_meta_reg;
  reg        present_sync_reg;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_reg     <= 16'h0000;
      tick_reg         <= 1'b0;
      present_meta_reg <= 1'b0;
      present_sync_reg <= 1'b0;
    end else begin
      present_meta_reg <= i_sensor_present;
      present_sync_reg <= present_meta_reg;
      if ({16'h0000, tick_cnt_reg} == `TICK_CYCLES - 1) begin
        tick_cnt_reg <= 16'h0000;
        tick_reg     <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        tick_reg     <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Power unit supervision
  // Alarms sit at or below the fixed trips, so an alarm always shows by the
  // time the trip does.
  wire i2t_alarm_c = gte(i_converter_load_pct, i2t_alarm_reg) ||
                     ($signed(i_converter_load_pct) > $signed(`LOAD_TRIP_PCT));
  wire i2t_trip_c  = $signed(i_converter_load_pct) > $signed(`LOAD_TRIP_PCT);
  wire hs_trip_c   = gte(i_heatsink_temp, `HS_TRIP_C);
  wire hs_alarm_c  = hs_trip_c || gte(i_heatsink_temp, `HS_TRIP_C - hs_margin_reg);
  wire jt_trip_c   = gte(i_junction_temp, `JT_TRIP_C);
  wire jt_alarm_c  = jt_trip_c || gte(i_junction_temp, `JT_TRIP_C - jt_margin_reg);
  wire air_alarm_c = gte(i_inlet_air_temp, `AIR_TRIP_C - `AIR_MARGIN_K);
  wire pu_alarm_c  = i2t_alarm_c | hs_alarm_c | jt_alarm_c | air_alarm_c;
  wire pu_trip_c   = i2t_trip_c | hs_trip_c | jt_trip_c;

  // Response is registered together with the alarm, same edge.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_i2t_alarm           <= 1'b0;
      o_i2t_trip            <= 1'b0;
      o_heatsink_alarm      <= 1'b0;
      o_heatsink_trip       <= 1'b0;
      o_junction_temp_alarm <= 1'b0;
      o_junction_temp_trip  <= 1'b0;
      o_inlet_air_alarm     <= 1'b0;
      o_pulse_freq_reduce   <= 1'b0;
      o_output_freq_reduce  <= 1'b0;
      o_power_off           <= 1'b0;
    end else begin
      o_i2t_alarm           <= i2t_alarm_c;
      o_heatsink_alarm      <= hs_alarm_c;
      o_junction_temp_alarm <= jt_alarm_c;
      o_inlet_air_alarm     <= air_alarm_c;
      // Trips latch until reset: shutdown is not undone by cooling.
      o_i2t_trip            <= o_i2t_trip | i2t_trip_c;
      o_heatsink_trip       <= o_heatsink_trip | hs_trip_c;
      o_junction_temp_trip  <= o_junction_temp_trip | jt_trip_c;
      o_pulse_freq_reduce   <= pu_alarm_c && resp_sel[1];
      o_output_freq_reduce  <= pu_alarm_c && !resp_sel[0];
      o_power_off           <= o_power_off | pu_trip_c;
    end
  end

  // ==========================================================================
  // Blocked and stalled motor
  wire [31:0] chg_product = chg_speed_reg * chg_hyst_reg;
  wire blocked_c = (i_speed_abs < block_speed_reg) &&
                   (i_vector_control ? i_speed_ctrl_at_limit
                                     : i_current_limit_reached);
  wire dev_c     = i_encoder_closed_loop &&
                   (i_speed_deviation > stall_speed_reg);
  wire lowstall_c = ({16'h0000, i_speed_abs} < chg_product) &&
                    (i_model_error > stall_fault_reg);
  wire blocked_exp;
  wire stalled_exp;

  delay_timer u_block_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_reg),
    .i_cond    (blocked_c),
    .i_delay   (block_delay_reg),
    .o_expired (blocked_exp)
  );

  delay_timer u_stall_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_reg),
    .i_cond    (dev_c | lowstall_c),
    .i_delay   (stall_delay_reg),
    .o_expired (stalled_exp)
  );

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_motor_blocked             <= 1'b0;
      o_motor_blocked_trip        <= 1'b0;
      o_control_status_word_three <= 16'h0000;
      o_motor_stalled_trip        <= 1'b0;
    end else begin
      o_motor_blocked      <= blocked_exp;
      o_motor_blocked_trip <= o_motor_blocked_trip | blocked_exp;
      o_control_status_word_three <= {3'h0, lowstall_c, dev_c, 11'h000};
      o_motor_stalled_trip <= o_motor_stalled_trip | stalled_exp;
    end
  end

  // ==========================================================================
  // Motor temperature
  wire ext_src    = (temp_src == `SRC_EXTERNAL);
  wire is_linear  = ext_src && (sens_kind == `KIND_LINEAR);
  wire is_ptc     = ext_src && (sens_kind == `KIND_PTC);
  wire ptc_hot    = i_ptc_ohm > `PTC_TRIP_OHM;
  wire [15:0] ptc_temp = ptc_hot ? `PTC_HOT_C : `PTC_COLD_C;
  wire [15:0] lin_temp = sat(i_sensor_temp, `LIN_MIN_C, `LIN_MAX_C);
  // Range check looks at the raw reading, before saturation hides it.
  wire sens_bad_c = is_linear && present_sync_reg &&
                    (($signed(i_sensor_temp) < $signed(`PTC_COLD_C)) ||
                     ($signed(i_sensor_temp) > $signed(`PTC_HOT_C)));
  wire lin_alarm_c = is_linear && gte(lin_temp, mot_alarm_reg);
  wire lin_trip_c  = is_linear && gte(lin_temp, mot_trip_reg);
  wire ot_alarm_c  = lin_alarm_c | (is_ptc && ptc_hot);
  wire ptc_trip_exp;
  wire sens_exp;

  delay_timer u_ptc_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_reg),
    .i_cond    (is_ptc && ptc_hot),
    .i_delay   (mot_timer_reg),
    .o_expired (ptc_trip_exp)
  );

  delay_timer u_sens_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (tick_reg),
    .i_cond    (sens_bad_c),
    .i_delay   (sens_timer_reg),
    .o_expired (sens_exp)
  );

  // Response 0 never trips; 1 trips and cuts the current ceiling.
  wire trip_allowed = (mot_resp == 2'h1) || (mot_resp == 2'h2);
  wire ot_trip_c    = trip_allowed && (lin_trip_c | ptc_trip_exp);

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_motor_temp             <= 16'h0000;
      o_motor_overtemp_alarm   <= 1'b0;
      o_motor_overtemp_trip    <= 1'b0;
      o_current_ceiling_reduce <= 1'b0;
      o_sensor_fault_alarm     <= 1'b0;
      o_sensor_fault_trip      <= 1'b0;
      o_sensor_missing_alarm   <= 1'b0;
      o_use_model_temp         <= 1'b0;
    end else begin
      o_motor_temp <= is_ptc ? ptc_temp : (is_linear ? lin_temp : 16'h0000);
      o_motor_overtemp_alarm   <= ot_alarm_c;
      o_motor_overtemp_trip    <= o_motor_overtemp_trip | ot_trip_c;
      o_current_ceiling_reduce <= ot_alarm_c && (mot_resp == 2'h1);
      o_sensor_fault_alarm     <= sens_bad_c;
      // Zero timer suppresses the trip rather than tripping at once.
      o_sensor_fault_trip <= o_sensor_fault_trip |
                             (sens_exp && (sens_timer_reg != 16'h0000));
      o_use_model_temp <= sens_bad_c && induction &&
                          (sens_timer_reg == 16'h0000);
      o_sensor_missing_alarm <= ext_src && !present_sync_reg;
    end
  end

endmodule

// ### shared/drive_protection_monitor_consts.vh
// Constants for the drive protection monitor: register indices, field
// positions, reset values, fixed thresholds and timing counts.
// Assumes a 25 MHz monitoring clock and signed temperatures in degrees C.
`ifndef DRIVE_PROTECTION_MONITOR_CONSTS_VH
`define DRIVE_PROTECTION_MONITOR_CONSTS_VH

// Register indices.
`define REG_CTRL            4'h0
`define REG_I2T_ALARM       4'h1
`define REG_HS_MARGIN       4'h2
`define REG_JT_MARGIN       4'h3
`define REG_BLOCK_SPEED     4'h4
`define REG_BLOCK_DELAY     4'h5
`define REG_STALL_SPEED     4'h6
`define REG_STALL_FAULT     4'h7
`define REG_CHG_SPEED       4'h8
`define REG_CHG_HYST        4'h9
`define REG_STALL_DELAY     4'ha
`define REG_MOT_ALARM_LVL   4'hb
`define REG_MOT_TRIP_LVL    4'hc
`define REG_MOT_TIMER       4'hd
`define REG_SENS_TIMER      4'he
`define REG_STATUS          4'hf

// Control register fields.
`define CTRL_RESP_LSB       0
`define CTRL_SRC_LSB        2
`define CTRL_KIND_LSB       6
`define CTRL_MRESP_LSB      8
`define CTRL_INDUCTION_BIT  10
`define CTRL_RESET          16'h0000

// Codes.
`define SRC_EXTERNAL        4'ha
`define KIND_PTC            2'h1
`define KIND_LINEAR         2'h2

// Fixed levels and register reset values; loads in percent, temperatures in degrees C.
`define LOAD_TRIP_PCT       16'sh0064
`define I2T_ALARM_RESET     16'h005f
`define HS_TRIP_C           16'sh005a
`define JT_TRIP_C           16'sh0096
`define AIR_TRIP_C          16'sh0037
`define HS_MARGIN_RESET     16'h0005
`define JT_MARGIN_RESET     16'h000f
`define AIR_MARGIN_K        16'sh0005
`define LIN_MIN_C           16'shffd0
`define LIN_MAX_C           16'sh00f8
`define PTC_COLD_C          16'shffce
`define PTC_HOT_C           16'sh00fa
`define PTC_TRIP_OHM        16'h0672
`define MOT_ALARM_RESET     16'h0078
`define MOT_TRIP_RESET      16'h0091
`define CHG_HYST_RESET      16'h0001

// Delay registers count milliseconds.
`define TICK_NS             1000000
`define CLK_NS              40
`define TICK_CYCLES         (`TICK_NS / `CLK_NS)

`endif

// ### rtl/delay_timer.v
// Millisecond delay timer: counts ticks while a condition holds.
// Assumes a one-cycle tick enable from the same clock.
`timescale 1ns/100ps
module delay_timer (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_tick,
  input  wire        i_cond,
  input  wire [15:0] i_delay,
  output wire        o_expired
);
  reg [15:0] count_reg;

  // Restart from zero whenever the condition drops.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 16'h0000;
    end else if (!i_cond) begin
      count_reg <= 16'h0000;
    end else if (i_tick && count_reg < i_delay) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign o_expired = i_cond && (count_reg >= i_delay);
endmodule

// ### dv/drive_protection_monitor_monitor.sv
// Checker for the protection monitor, built on its top-level ports only.
// Assumes alarms and responses are registered one cycle after their cause.
`timescale 1ns/100ps
module drive_protection_monitor_monitor (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire [3:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        i_wr,
  input wire [15:0] i_converter_load_pct,
  input wire [15:0] i_heatsink_temp,
  input wire [15:0] i_ptc_ohm,
  input wire        i_sensor_present,
  input wire        o_i2t_alarm,
  input wire        o_heatsink_alarm,
  input wire        o_heatsink_trip,
  input wire        o_junction_temp_alarm,
  input wire        o_inlet_air_alarm,
  input wire        o_pulse_freq_reduce,
  input wire        o_output_freq_reduce,
  input wire        o_motor_blocked,
  input wire        o_motor_blocked_trip,
  input wire [15:0] o_control_status_word_three,
  input wire        o_motor_stalled_trip,
  input wire [15:0] o_motor_temp,
  input wire        o_motor_overtemp_alarm,
  input wire        o_sensor_fault_trip,
  input wire        o_sensor_missing_alarm
);
  reg  [15:0] ctrl_q;
  reg  [15:0] st_q;
  wire        cw = i_wr && i_addr == 4'h0;
  wire        ext = ctrl_q[5:2] == 4'ha;
  wire [1:0]  stall_bits = o_control_status_word_three[12:11];
  wire        any_al = o_i2t_alarm | o_heatsink_alarm | o_junction_temp_alarm | o_inlet_air_alarm;
  // ==========================================================================
  // Settings shadow
  // The properties need the live settings, so control and sensor timer register writes are mirrored.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= 16'h0000;
      st_q   <= 16'h0000;
    end else begin
      if (cw) begin
        ctrl_q <= i_wdata;
      end
      if (i_wr && i_addr == 4'he) begin
        st_q <= i_wdata;
      end
    end
  end
  // ==========================================================================
  // Properties
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  i2t_over_a: assert property ($signed(i_converter_load_pct) > 16'sh0064
    |=> o_i2t_alarm) else $error("i2t alarm missing");
  hs_fixed_a: assert property ($signed(i_heatsink_temp) > 16'sh005a
    |=> o_heatsink_trip) else $error("heatsink trip missing");
  hs_order_a: assert property ($rose(o_heatsink_trip) |-> o_heatsink_alarm)
    else $error("heatsink trip without alarm");
  pulse_resp_a: assert property (!$past(cw)
    |-> o_pulse_freq_reduce == (any_al && ctrl_q[1])) else $error("pulse reduce wrong");
  out_resp_a: assert property (!$past(cw)
    |-> o_output_freq_reduce == (any_al && !ctrl_q[0])) else $error("output reduce wrong");
  blocked_pair_a: assert property (o_motor_blocked |-> o_motor_blocked_trip)
    else $error("blocked without trip");
  stall_cause_a: assert property ($rose(o_motor_stalled_trip)
    |-> stall_bits != 2'b00) else $error("stall trip without cause");
  lin_clamp_a: assert property (ext && ctrl_q[7:6] == 2'h2 && !$past(cw)
    |-> $signed(o_motor_temp) >= 16'shffd0 && $signed(o_motor_temp) <= 16'sh00f8)
    else $error("linear temperature out of clamp");
  ptc_alarm_a: assert property ((ext && ctrl_q[7:6] == 2'h1 && i_sensor_present
    && i_ptc_ohm > 16'h0672 && !cw) [*3] |=> o_motor_overtemp_alarm)
    else $error("ptc alarm late");
  sens_supp_a: assert property ($rose(o_sensor_fault_trip) |-> $past(st_q) != 16'h0000)
    else $error("sensor trip while suppressed");
  sensor_missing_a: assert property ((ext && ctrl_q[7:6] != 2'h0 && !i_sensor_present
    && !cw) [*3] |=> o_sensor_missing_alarm) else $error("missing alarm late");
endmodule

// ### dv/drive_plant_model.sv
// Power stage and motor temperature sensor as seen by the monitor.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/100ps
module drive_plant_model (
  input  wire        i_ref_clk,
  input  wire [15:0] i_load_cmd,
  input  wire [15:0] i_temp_cmd,
  input  wire [15:0] i_ohm_cmd,
  input  wire        i_present_cmd,
  input  wire        i_power_off,
  output reg  [15:0] o_load = 16'h0000,
  output reg  [15:0] o_sensor_temp = 16'h0000,
  output reg  [15:0] o_ptc_ohm = 16'h0000,
  output reg         o_present = 1'b1
);
  always @(posedge i_ref_clk) begin
    // Pulses are off after a shutdown, so the stage carries no load.
    o_load <= i_power_off ? 16'h0000 : i_load_cmd;
    o_present <= i_present_cmd;
    // An unplugged sensor line never settles, so it toggles every cycle.
    o_sensor_temp <= i_present_cmd ? i_temp_cmd : ~o_sensor_temp;
    o_ptc_ohm <= i_present_cmd ? i_ohm_cmd : ~o_ptc_ohm;
  end
endmodule

// ### dv/drive_protection_monitor_tb.sv
// Self-checking bench for the protection monitor with a plant model.
// Assumes a 25 MHz clock and one-cycle register strobes.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module drive_protection_monitor_tb;
  reg         i_ref_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg  [3:0]  i_addr = 4'h0;
  reg  [15:0] i_wdata = 16'h0000;
  reg         i_wr = 1'b0;
  reg         i_rd = 1'b0;
  reg  [15:0] i_heatsink_temp = 16'h0000, i_junction_temp = 16'h0000;
  reg  [15:0] i_inlet_air_temp = 16'h0000, i_speed_abs = 16'h0000;
  reg  [15:0] i_speed_deviation = 16'h0000, i_model_error = 16'h0000;
  reg         i_vector_control = 1'b0, i_encoder_closed_loop = 1'b0;
  reg         i_speed_ctrl_at_limit = 1'b0, i_current_limit_reached = 1'b0;
  reg  [15:0] load_cmd = 16'h0000, temp_cmd = 16'h0000, ohm_cmd = 16'h0000;
  reg         present_cmd = 1'b1;
  wire [15:0] i_converter_load_pct, i_sensor_temp, i_ptc_ohm, o_rdata, o_motor_temp;
  wire [15:0] o_control_status_word_three;
  wire        i_sensor_present, o_i2t_alarm, o_i2t_trip, o_heatsink_alarm, o_heatsink_trip;
  wire        o_junction_temp_alarm, o_junction_temp_trip, o_inlet_air_alarm, o_power_off;
  wire        o_pulse_freq_reduce, o_output_freq_reduce, o_motor_blocked;
  wire        o_motor_blocked_trip, o_motor_stalled_trip, o_motor_overtemp_alarm;
  wire        o_motor_overtemp_trip, o_current_ceiling_reduce, o_sensor_fault_alarm;
  wire        o_sensor_fault_trip, o_sensor_missing_alarm, o_use_model_temp;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         dv, me, sp, t;
  int         tq[$];
  drive_protection_monitor i_drive_protection_monitor (.*);
  drive_plant_model i_drive_plant_model (
    .i_ref_clk     (i_ref_clk),
    .i_load_cmd    (load_cmd),
    .i_temp_cmd    (temp_cmd),
    .i_ohm_cmd     (ohm_cmd),
    .i_present_cmd (present_cmd),
    .i_power_off   (o_power_off),
    .o_load        (i_converter_load_pct),
    .o_sensor_temp (i_sensor_temp),
    .o_ptc_ohm     (i_ptc_ohm),
    .o_present     (i_sensor_present)
  );
  // ==========================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(input [3:0] a, input [15:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, input [15:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  task automatic do_reset;
    i_rst <= 1'b1;
    tick(20);
    i_rst <= 1'b0;
    tick(2);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic int clampt(int v);
    return v < -48 ? -48 : (v > 248 ? 248 : v);
  endfunction
  always #20 i_ref_clk = ~i_ref_clk;
  // The longest wait is two stall segments of just under one tick each.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(1615));
    do_reset();
    rd(4'h1, 16'h005f);
    rd(4'h3, 16'h000f);
    rd(4'hb, 16'h0078);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    wr(4'h2, 16'h0014);
    rd(4'h2, 16'h0014);
    for (int s = 0; s < 4; s++) begin
      wr(4'h0, 16'(s));
      load_cmd <= 16'h0060;
      tick(6);
      `CHK(o_i2t_alarm, 1'b1)
      `CHK(o_pulse_freq_reduce, 1'(s >= 2))
      `CHK(o_output_freq_reduce, 1'(s % 2 == 0))
      load_cmd <= 16'h0000;
      tick(6);
    end
    wr(4'h0, 16'h0001);
    i_heatsink_temp <= 16'h0048;
    i_junction_temp <= 16'h0088;
    i_inlet_air_temp <= 16'h0034;
    tick(6);
    `CHK({o_heatsink_alarm, o_heatsink_trip}, 2'b10)
    `CHK({o_junction_temp_alarm, o_junction_temp_trip, o_inlet_air_alarm}, 3'b101)
    i_heatsink_temp <= 16'h005b;
    i_junction_temp <= 16'h0097;
    load_cmd <= 16'h0065;
    tick(6);
    `CHK({o_heatsink_trip, o_junction_temp_trip, o_i2t_trip}, 3'b111)
    `CHK({o_power_off, o_pulse_freq_reduce, o_output_freq_reduce}, 3'b100)
    i_heatsink_temp <= 16'h0000;
    i_junction_temp <= 16'h0000;
    load_cmd <= 16'h0000;
    do_reset();
    wr(4'h4, 16'h0064);
    wr(4'h5, 16'h0000);
    i_speed_abs <= 16'h0032;
    i_vector_control <= 1'b1;
    i_current_limit_reached <= 1'b1;
    tick(8);
    `CHK(o_motor_blocked, 1'b0)
    i_speed_ctrl_at_limit <= 1'b1;
    tick(8);
    `CHK({o_motor_blocked, o_motor_blocked_trip}, 2'b11)
    i_speed_abs <= 16'h0096;
    tick(8);
    `CHK(o_motor_blocked, 1'b0)
    i_speed_ctrl_at_limit <= 1'b0;
    i_vector_control <= 1'b0;
    i_speed_abs <= 16'h0032;
    tick(8);
    `CHK(o_motor_blocked, 1'b1)
    i_encoder_closed_loop <= 1'b1;
    wr(4'h6, 16'h00c8);
    wr(4'h7, 16'h012c);
    wr(4'h8, 16'h0064);
    wr(4'h9, 16'h0002);
    wr(4'ha, 16'h0002);
    repeat (8) begin
      dv = $urandom % 400;
      me = $urandom % 600;
      sp = $urandom % 400;
      i_speed_deviation <= 16'(dv);
      i_model_error <= 16'(me);
      i_speed_abs <= 16'(sp);
      tick(6);
      `CHK(o_control_status_word_three[11], dv > 200)
      `CHK(o_control_status_word_three[12], sp < 200 && me > 300)
    end
    i_model_error <= 16'h0000;
    for (int k = 0; k < 3; k++) begin
      i_speed_deviation <= 16'h0000;
      tick(4);
      i_speed_deviation <= 16'h012c;
      tick(k < 2 ? 24990 : 0);
    end
    `CHK(o_motor_stalled_trip, 1'b0)
    wr(4'ha, 16'h0000);
    tick(6);
    `CHK(o_motor_stalled_trip, 1'b1)
    wr(4'he, 16'h0000);
    wr(4'h0, 16'h04a8);
    tq = '{-50, -49, -48, 119, 120, 248, 249, 250};
    repeat (6) tq.push_back(int'($urandom % 301) - 50);
    while (tq.size() > 0) begin
      t = tq.pop_front();
      temp_cmd <= 16'(t);
      tick(6);
      `CHK(o_motor_temp, 16'(clampt(t)))
      `CHK(o_motor_overtemp_alarm, clampt(t) >= 120)
      `CHK({o_sensor_fault_alarm, o_motor_overtemp_trip}, 2'b00)
    end
    for (int k = 0; k < 2; k++) begin
      temp_cmd <= k ? 16'h00fb : 16'hffcd;
      tick(6);
      `CHK(o_sensor_fault_alarm, 1'b1)
      `CHK({o_sensor_fault_trip, o_use_model_temp}, 2'b01)
    end
    temp_cmd <= 16'h008c;
    wr(4'h0, 16'h06a8);
    tick(6);
    `CHK(o_motor_overtemp_trip, 1'b0)
    temp_cmd <= 16'h0092;
    tick(6);
    `CHK({o_motor_overtemp_trip, o_current_ceiling_reduce}, 2'b10)
    do_reset();
    wr(4'h0, 16'h05a8);
    tick(6);
    `CHK({o_motor_overtemp_trip, o_current_ceiling_reduce}, 2'b11)
    do_reset();
    wr(4'hd, 16'h0000);
    wr(4'h0, 16'h0268);
    ohm_cmd <= 16'h0672;
    tick(6);
    `CHK({o_motor_temp, o_motor_overtemp_alarm}, {16'hffce, 1'b0})
    ohm_cmd <= 16'h0673;
    tick(6);
    `CHK(o_motor_temp, 16'h00fa)
    `CHK({o_motor_overtemp_alarm, o_motor_overtemp_trip}, 2'b11)
    present_cmd <= 1'b0;
    tick(6);
    `CHK(o_sensor_missing_alarm, 1'b1)
    wrap_up();
  end
endmodule
bind drive_protection_monitor drive_protection_monitor_monitor i_drive_protection_monitor_monitor (.*);
